// ==== logic/ubs_core.sv ====
// USB bus state, reset, sleep/wake and isochronous OUT reception
`timescale 1ns/1ps
`default_nettype none
module ubs_core
	import ubs_pkg::*;
#(
	parameter int IDLE_CYCLES = UBS_IDLE_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic deep_power_mode,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_word,
	output logic [15:0] reg_rdata,
	input wire logic [1:0] line_state,
	input wire logic xfer_done,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_pkt_start,
	input wire logic rx_pkt_end,
	input wire logic rx_bit_error,
	input wire logic rx_buf_free,
	output logic [6:0] match_addr,
	output logic drive_resume,
	output logic cpu_usb_irq_flag,
	input wire logic cpu_usb_irq_enable,
	output logic irq_req,
	output logic wake_req,
	output logic dma_trigger
);
	// Line state from the pins, two flops
	logic [1:0] line_s1_q, line_s2_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			line_s1_q <= UBS_LINE_IDLE;
			line_s2_q <= UBS_LINE_IDLE;
		end else begin
			line_s1_q <= line_state;
			line_s2_q <= line_s1_q;
		end
	end
	// Controller reset also on deep power mode
	wire ctl_rst = rst || deep_power_mode;
	wire line_reset = (line_s2_q == UBS_LINE_RESET);
	wire line_active = (line_s2_q == UBS_LINE_ACTIVE);
	wire line_idle = (line_s2_q == UBS_LINE_IDLE);
	logic line_reset_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			line_reset_q <= 1'b0;
		else
			line_reset_q <= line_reset;
	end
	wire bus_reset = line_reset && !line_reset_q;

	// Register decode
	wire in_win = (reg_addr >= UBS_WIN_BASE) && (reg_addr <= UBS_WIN_LAST);
	wire in_rsvd = (reg_addr >= UBS_RSVD_FIRST);
	wire [5:0] off = reg_addr[5:0];
	wire hit = in_win && !in_rsvd;

	// Live register at one offset; reserved and outside addresses never match
	function automatic logic at_off(
		input logic [15:0] a,
		input logic [5:0] o
	);
		logic live;
		live = (a >= UBS_WIN_BASE) && (a < UBS_RSVD_FIRST);
		return live && (a[5:0] == o);
	endfunction

	// Any flag whose enable is set
	function automatic logic any_enabled(
		input logic [3:0] f,
		input logic [7:0] en
	);
		return |(f & en[3:0]);
	endfunction

	wire wr_faddr = reg_wr && at_off(reg_addr, UBS_OFF_FADDR);
	wire wr_pow = reg_wr && at_off(reg_addr, UBS_OFF_POWER);
	wire wr_cie = reg_wr && at_off(reg_addr, UBS_OFF_CIE);
	wire wr_idx = reg_wr && at_off(reg_addr, UBS_OFF_INDEX);
	wire wr_cso = reg_wr && at_off(reg_addr, UBS_OFF_CSO);
	wire wr_ord = reg_wr && at_off(reg_addr, UBS_OFF_ORDER);
	wire rd_cif = reg_rd && at_off(reg_addr, UBS_OFF_CIF);
	wire rd_fifo = reg_rd && at_off(reg_addr, UBS_OFF_FIFO);

	// Function address and update bit
	logic [6:0] faddr_q, eff_addr_q;
	logic upd_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst) begin
			faddr_q <= '0;
			eff_addr_q <= '0;
			upd_q <= 1'b0;
		end else if (bus_reset) begin
			faddr_q <= '0;
			eff_addr_q <= '0;
			upd_q <= 1'b0;
		end else if (wr_faddr) begin
			faddr_q <= reg_wdata[6:0];
			upd_q <= 1'b1;
		end else if (upd_q && xfer_done) begin
			eff_addr_q <= faddr_q;
			upd_q <= 1'b0;
		end
	end
	assign match_addr = eff_addr_q;

	// Endpoint select
	logic [3:0] ep_sel_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			ep_sel_q <= '0;
		else if (bus_reset)
			ep_sel_q <= '0;
		else if (wr_idx && reg_wdata[3:0] <= UBS_EP_COUNT)
			ep_sel_q <= reg_wdata[3:0];
	end

	// Power control
	logic iso_wait_q, resume_q, susp_en_q, sleeping_q;
	wire resume_rise = wr_pow && reg_wdata[UBS_POW_RESUME] && !resume_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst) begin
			iso_wait_q <= 1'b0;
			resume_q <= 1'b0;
			susp_en_q <= 1'b0;
		end else if (wr_pow) begin
			iso_wait_q <= reg_wdata[UBS_POW_ISO_WAIT];
			resume_q <= reg_wdata[UBS_POW_RESUME];
			susp_en_q <= reg_wdata[UBS_POW_SUSP_EN];
		end
	end
	assign drive_resume = resume_q;

	// Idle counter for sleep entry
	localparam int CW = $clog2(IDLE_CYCLES + 1);
	logic [CW-1:0] idle_cnt_q;
	wire idle_done = (idle_cnt_q == CW'(IDLE_CYCLES - 1));
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			idle_cnt_q <= '0;
		else if (!line_idle || !susp_en_q || sleeping_q)
			idle_cnt_q <= '0;
		else if (!idle_done)
			idle_cnt_q <= CW'(idle_cnt_q + 1'b1);
	end
	wire enter_sleep = susp_en_q && line_idle && idle_done && !sleeping_q;
	wire wake_event = sleeping_q && line_active;
	wire reset_wake = sleeping_q && bus_reset;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			sleeping_q <= 1'b0;
		else if (enter_sleep)
			sleeping_q <= 1'b1;
		else if (rd_cif || resume_rise || wake_event || reset_wake)
			sleeping_q <= 1'b0;
	end

	// Common interrupt enables
	logic [7:0] cie_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			cie_q <= UBS_CIE_RESET;
		else if (bus_reset)
			cie_q <= UBS_CIE_RESET;
		else if (wr_cie)
			cie_q <= reg_wdata[7:0];
	end

	// Common flags, clear on read, set wins
	logic [3:0] cif_q, cif_set;
	always_comb begin
		cif_set = '0;
		cif_set[UBS_CIF_RST] = bus_reset;
		cif_set[UBS_CIF_RESUME] = wake_event;
		cif_set[UBS_CIF_SUSP] = enter_sleep;
	end
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			cif_q <= '0;
		else
			cif_q <= cif_set | (rd_cif ? 4'h0 : cif_q);
	end
	wire cpu_set = any_enabled(cif_set, cie_q);
	wire cpu_keep = any_enabled(cif_q, cie_q);

	// CPU USB flag and interrupt request
	logic cpu_flag_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			cpu_flag_q <= 1'b0;
		else if (cpu_set)
			cpu_flag_q <= 1'b1;
		else if (!cpu_keep)
			cpu_flag_q <= 1'b0;
	end
	assign cpu_usb_irq_flag = cpu_flag_q;
	assign irq_req = cpu_flag_q && cpu_usb_irq_enable;
	assign wake_req = (wake_event && cie_q[UBS_CIF_RESUME]) || reset_wake;
	assign dma_trigger = 1'b0;

	// Iso OUT reception
	logic pkt_q, drop_q, cso_ovr_q, cso_err_q, err_acc_q;
	logic [7:0] cso_other_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst) begin
			pkt_q <= 1'b0;
			drop_q <= 1'b0;
			err_acc_q <= 1'b0;
		end else if (bus_reset) begin
			pkt_q <= 1'b0;
			drop_q <= 1'b0;
			err_acc_q <= 1'b0;
		end else if (rx_pkt_start) begin
			pkt_q <= 1'b1;
			drop_q <= !rx_buf_free;
			err_acc_q <= 1'b0;
		end else if (rx_pkt_end) begin
			pkt_q <= 1'b0;
			err_acc_q <= 1'b0;
		end else if (rx_bit_error) begin
			err_acc_q <= 1'b1;
		end
	end
	wire set_ovr = rx_pkt_start && !rx_buf_free;
	wire set_err = rx_pkt_end && (err_acc_q || rx_bit_error) && !drop_q;
	wire clr_cso = bus_reset;
	// Firmware clears a status bit by writing zero to it
	wire ovr_wclr = wr_cso && !reg_wdata[UBS_CSO_OVERRUN];
	wire err_wclr = wr_cso && !reg_wdata[UBS_CSO_DATA_ERR];
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst) begin
			cso_ovr_q <= 1'b0;
			cso_err_q <= 1'b0;
			cso_other_q <= '0;
		end else begin
			// Set wins over any clear in the same cycle
			if (set_ovr)
				cso_ovr_q <= 1'b1;
			else if (clr_cso || ovr_wclr)
				cso_ovr_q <= 1'b0;
			if (set_err)
				cso_err_q <= 1'b1;
			else if (clr_cso || err_wclr)
				cso_err_q <= 1'b0;
			if (clr_cso)
				cso_other_q <= UBS_ZERO8;
			else if (wr_cso)
				cso_other_q <= reg_wdata[7:0];
		end
	end
	wire [7:0] cso_view = {cso_other_q[7:4], cso_err_q, cso_ovr_q, cso_other_q[1:0]};

	// Endpoint FIFO, flushed by bus reset
	logic [7:0] fifo_out;
	logic fifo_ovalid;
	logic [2:0] fifo_lvl;
	wire accept = rx_valid && pkt_q && !drop_q;
	wire fifo_iready;
	assign rx_ready = fifo_iready || drop_q || !pkt_q;
	wire word_rd = rd_fifo && reg_word;
	wire fifo_pop = rd_fifo && fifo_ovalid;
	ubs_fifo #(.W(UBS_FIFO_W), .D(UBS_FIFO_D)) u_fifo (
		.mclk(mclk),
		.rst(ctl_rst),
		.flush(bus_reset),
		.in_valid(accept),
		.in_ready(fifo_iready),
		.in_data(rx_data),
		.out_valid(fifo_ovalid),
		.out_ready(rd_fifo),
		.out_data(fifo_out),
		.level(fifo_lvl)
	);

	// Word assembly: first byte popped, second byte on next pop
	logic [7:0] first_q;
	logic half_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst) begin
			first_q <= '0;
			half_q <= 1'b0;
		end else if (bus_reset) begin
			half_q <= 1'b0;
		end else if (fifo_pop && word_rd) begin
			first_q <= fifo_out;
			half_q <= !half_q;
		end
	end

	// Byte order
	logic rd_big_q, wr_big_q;
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst) begin
			rd_big_q <= 1'b0;
			wr_big_q <= 1'b0;
		end else if (wr_ord) begin
			rd_big_q <= reg_wdata[UBS_ORD_RD];
			wr_big_q <= reg_wdata[UBS_ORD_WR];
		end
	end
	// Big endian puts the first FIFO byte in the high half
	wire [15:0] word_le = {fifo_out, first_q};
	wire [15:0] word_be = {first_q, fifo_out};
	wire [15:0] word_val = rd_big_q ? word_be : word_le;

	// Read data mux
	wire [7:0] pow_view = {iso_wait_q, 3'b000, line_reset, resume_q, sleeping_q, susp_en_q};
	logic [15:0] rd_d, rdata_q;
	always_comb begin
		rd_d = '0;
		if (hit) begin
			unique case (off)
				UBS_OFF_FADDR: rd_d = {8'h00, upd_q, faddr_q};
				UBS_OFF_POWER: rd_d = {8'h00, pow_view};
				UBS_OFF_CIF: rd_d = {12'h000, cif_q};
				UBS_OFF_CIE: rd_d = {8'h00, cie_q};
				UBS_OFF_INDEX: rd_d = {12'h000, ep_sel_q};
				UBS_OFF_CSO: rd_d = {8'h00, cso_view};
				UBS_OFF_ORDER: rd_d = {14'h0000, wr_big_q, rd_big_q};
				UBS_OFF_FIFO: rd_d = (word_rd && half_q) ? word_val : {8'h00, fifo_out};
				default: rd_d = '0;
			endcase
		end
	end
	always_ff @(posedge mclk or posedge ctl_rst) begin
		if (ctl_rst)
			rdata_q <= '0;
		else if (reg_rd)
			rdata_q <= rd_d;
	end
	assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ==== logic/ubs_pkg.sv ====
// Constants shared by the USB bus-state and isochronous OUT block
package ubs_pkg;
	// Register window: byte addresses in the data space
	localparam logic [15:0] UBS_WIN_BASE = 16'hDE00;
	localparam logic [15:0] UBS_WIN_LAST = 16'hDE3F;
	localparam logic [15:0] UBS_RSVD_FIRST = 16'hDE2C;
	localparam logic [5:0] UBS_OFF_FADDR = 6'h00;
	localparam logic [5:0] UBS_OFF_POWER = 6'h01;
	localparam logic [5:0] UBS_OFF_CIF = 6'h06;
	localparam logic [5:0] UBS_OFF_CIE = 6'h0B;
	localparam logic [5:0] UBS_OFF_INDEX = 6'h0E;
	localparam logic [5:0] UBS_OFF_CSO = 6'h11;
	localparam logic [5:0] UBS_OFF_ORDER = 6'h20;
	localparam logic [5:0] UBS_OFF_FIFO = 6'h21;
	// Field positions
	localparam int UBS_ADDR_UPD_BIT = 7;
	localparam int UBS_POW_ISO_WAIT = 7;
	localparam int UBS_POW_RST = 3;
	localparam int UBS_POW_RESUME = 2;
	localparam int UBS_POW_SUSP = 1;
	localparam int UBS_POW_SUSP_EN = 0;
	localparam int UBS_CIF_SOF = 3;
	localparam int UBS_CIF_RST = 2;
	localparam int UBS_CIF_RESUME = 1;
	localparam int UBS_CIF_SUSP = 0;
	localparam int UBS_CSO_DATA_ERR = 3;
	localparam int UBS_CSO_OVERRUN = 2;
	localparam int UBS_ORD_RD = 0;
	localparam int UBS_ORD_WR = 1;
	// Reset values and endpoint count
	localparam logic [7:0] UBS_CIE_RESET = 8'h06;
	localparam logic [7:0] UBS_ZERO8 = 8'h00;
	localparam logic [3:0] UBS_EP_COUNT = 4'h5;
	// Timing: idle time before sleep
	localparam int UBS_CLK_MHZ = 125;
	localparam int UBS_IDLE_US = 3000;
	localparam int UBS_IDLE_CYC = UBS_IDLE_US * UBS_CLK_MHZ;
	// FIFO
	localparam int UBS_FIFO_W = 8;
	localparam int UBS_FIFO_D = 4;
	// Link line states seen by this block
	typedef enum logic [1:0] {
		UBS_LINE_IDLE = 2'b00,
		UBS_LINE_ACTIVE = 2'b01,
		UBS_LINE_RESET = 2'b10
	} ubs_line_t;
endpackage

// ==== logic/ubs_fifo.sv ====
// Small valid/ready FIFO for isochronous OUT data
`timescale 1ns/1ps
`default_nettype none
module ubs_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(D):0] level
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
	assign level = cnt_q;
	always_ff @(posedge mclk) begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= AW'(wp_q + 1'b1);
			if (pop)
				rp_q <= AW'(rp_q + 1'b1);
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end
endmodule
`default_nettype wire

// ==== tb/ubs_core_properties.sv ====
// Port-level checker for the USB bus-state block
`timescale 1ns/1ps
`default_nettype none
module ubs_core_properties
	import ubs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic deep_power_mode,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0] line_state,
	input wire logic xfer_done,
	input wire logic [6:0] match_addr,
	input wire logic drive_resume,
	input wire logic cpu_usb_irq_flag,
	input wire logic cpu_usb_irq_enable,
	input wire logic irq_req,
	input wire logic wake_req,
	input wire logic dma_trigger
);
	localparam logic [15:0] FA = UBS_WIN_BASE + UBS_OFF_FADDR;
	localparam logic [15:0] PW = UBS_WIN_BASE + UBS_OFF_POWER;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst || deep_power_mode);
	sequence addr_write;
		reg_wr && reg_addr == FA && !xfer_done;
	endsequence
	sequence addr_read;
		reg_rd && reg_addr == FA && !xfer_done;
	endsequence
	no_dma_a: assert property (dma_trigger == 1'b0)
		else $error("dma trigger raised");
	irq_gate_a: assert property (irq_req == (cpu_usb_irq_flag && cpu_usb_irq_enable))
		else $error("interrupt request not flag and enable");
	rsvd_zero_a: assert property (reg_rd && (reg_addr >= UBS_RSVD_FIRST ||
		reg_addr < UBS_WIN_BASE) |=> reg_rdata == 16'h0000)
		else $error("reserved read not zero");
	reset_addr_a: assert property ((line_state == UBS_LINE_RESET) [*4] |=>
		match_addr == 7'h00) else $error("address kept over bus reset");
	addr_change_a: assert property ($changed(match_addr) |->
		$past(xfer_done) || match_addr == 7'h00) else $error("address changed early");
	wake_pulse_a: assert property (wake_req |=> !wake_req)
		else $error("wake request longer than one cycle");
	resume_bit_a: assert property (reg_wr && reg_addr == PW |=>
		drive_resume == $past(reg_wdata[UBS_POW_RESUME])) else $error("resume drive wrong");
	addr_pending_a: assert property (addr_write ##1 !reg_wr && !xfer_done ##1 addr_read
		|=> reg_rdata[7:0] == {1'b1, $past(reg_wdata[6:0], 3)})
		else $error("pending address readback wrong");
endmodule
bind ubs_core ubs_core_properties i_ubs_core_properties (.mclk(mclk), .rst(rst),
	.deep_power_mode(deep_power_mode), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.line_state(line_state), .xfer_done(xfer_done), .match_addr(match_addr),
	.drive_resume(drive_resume), .cpu_usb_irq_flag(cpu_usb_irq_flag),
	.cpu_usb_irq_enable(cpu_usb_irq_enable), .irq_req(irq_req), .wake_req(wake_req),
	.dma_trigger(dma_trigger));
`default_nettype wire

// ==== tb/ubs_host_model.sv ====
// Host-side bus model: line states and isochronous OUT bytes
`timescale 1ns/1ps
`default_nettype none
module ubs_host_model
	import ubs_pkg::*;
(
	input wire logic mclk,
	output logic [1:0] ls,
	output logic rv,
	input wire logic rr,
	output logic [7:0] rd,
	output logic ps,
	output logic pe,
	output logic be
);
	initial begin
		ls = UBS_LINE_IDLE;
		rv = 1'b0;
		rd = 8'h00;
		ps = 1'b0;
		pe = 1'b0;
		be = 1'b0;
	end
	task automatic line(input logic [1:0] s, input int n);
		ls = s;
		repeat (n) @(posedge mclk);
		#1 ls = UBS_LINE_IDLE;
	endtask
	// Each byte waits a bounded time for room, then is given up
	task automatic send(input logic [7:0] b [$], input logic err);
		int k;
		ls = UBS_LINE_ACTIVE;
		ps = 1'b1;
		@(posedge mclk) #1;
		ps = 1'b0;
		foreach (b[i]) begin
			rv = 1'b1;
			rd = b[i];
			k = 0;
			while (rr !== 1'b1 && k < 8) begin
				@(posedge mclk) #1;
				k++;
			end
			@(posedge mclk) #1;
		end
		rv = 1'b0;
		rd = ~rd;
		pe = 1'b1;
		be = err;
		@(posedge mclk) #1;
		pe = 1'b0;
		be = 1'b0;
		ls = UBS_LINE_IDLE;
	endtask
endmodule
`default_nettype wire

// ==== tb/test_usb_device_bus_state_and_iso_out.sv ====
// Self-checking bench for the USB bus-state and iso OUT block
`timescale 1ns/1ps
`default_nettype none
module test_usb_device_bus_state_and_iso_out
	import ubs_pkg::*;
;
	logic mclk = 1'b0, rst = 1'b1, dpm = 1'b0, wr = 1'b0, rd = 1'b0, word = 1'b0;
	logic xd = 1'b0, bfree = 1'b1, cen = 1'b0;
	logic [15:0] ra = 16'h0000, wd = 16'h0000, lf = 16'h3C29, rdata;
	logic rv, rr, ps, pe, be, drs, cflg, irq, wk, dma;
	logic [1:0] ls;
	logic [7:0] rxd, b;
	logic [6:0] madr;
	logic [7:0] q [$], p [$];
	int n_mismatch = 0, total_checks = 0, n_wake = 0, cyc = 0;
	ubs_core #(.IDLE_CYCLES(50)) i_ubs_core (.mclk(mclk), .rst(rst), .deep_power_mode(dpm),
		.reg_addr(ra), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_word(word),
		.reg_rdata(rdata), .line_state(ls), .xfer_done(xd), .rx_valid(rv), .rx_ready(rr),
		.rx_data(rxd), .rx_pkt_start(ps), .rx_pkt_end(pe), .rx_bit_error(be),
		.rx_buf_free(bfree), .match_addr(madr), .drive_resume(drs), .cpu_usb_irq_flag(cflg),
		.cpu_usb_irq_enable(cen), .irq_req(irq), .wake_req(wk), .dma_trigger(dma));
	ubs_host_model i_ubs_host_model (.mclk(mclk), .ls(ls), .rv(rv), .rr(rr), .rd(rxd),
		.ps(ps), .pe(pe), .be(be));
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (wk === 1'b1) n_wake++;
		if (cyc == 4000) begin
			n_mismatch++;
			stop_test();
		end
	end
	function automatic logic [7:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [6:0] o, input logic [7:0] d);
		ra = UBS_WIN_BASE + o;
		wd = {8'h00, d};
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rchk(input logic [6:0] o, input logic [15:0] m, input logic [15:0] e);
		ra = UBS_WIN_BASE + o;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		chk(rdata & m, e);
		tick(1);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		tick(4);
		rst = 1'b0;
		tick(1);
		rchk(UBS_OFF_FADDR, 16'hFFFF, 16'h0000);
		rchk(UBS_OFF_CIE, 16'h00FF, {8'h00, UBS_CIE_RESET});
		wreg(7'h2C, 8'hFF);
		rchk(7'h2C, 16'hFFFF, 16'h0000);
		rchk(7'h40, 16'hFFFF, 16'h0000);
		$display("window test done");
		b = rnd();
		wreg(UBS_OFF_FADDR, b);
		rchk(UBS_OFF_FADDR, 16'h00FF, {9'h001, b[6:0]});
		chk({9'h000, madr}, 16'h0000);
		xd = 1'b1;
		tick(1);
		xd = 1'b0;
		chk({9'h000, madr}, {9'h000, b[6:0]});
		rchk(UBS_OFF_FADDR, 16'h00FF, {9'h000, b[6:0]});
		$display("address test done");
		wreg(UBS_OFF_INDEX, 8'h01);
		bfree = 1'b0;
		i_ubs_host_model.send('{rnd(), rnd()}, 1'b0);
		bfree = 1'b1;
		rchk(UBS_OFF_CSO, 16'h0004, 16'h0004);
		wreg(UBS_OFF_CSO, 8'h00);
		q = '{rnd(), rnd(), rnd(), rnd()};
		i_ubs_host_model.send(q, 1'b1);
		chk({15'h0000, rr}, 16'h0001);
		rchk(UBS_OFF_CSO, 16'h0008, 16'h0008);
		rchk(UBS_OFF_FIFO, 16'h00FF, {8'h00, q.pop_front()});
		wreg(UBS_OFF_ORDER, 8'h01);
		word = 1'b1;
		rchk(UBS_OFF_FIFO, 16'h00FF, {8'h00, q[0]});
		rchk(UBS_OFF_FIFO, 16'hFFFF, {q[0], q[1]});
		word = 1'b0;
		p = '{rnd(), rnd()};
		i_ubs_host_model.send(p, 1'b0);
		q = {q[2], p};
		rchk(UBS_OFF_FIFO, 16'h00FF, {8'h00, q[0]});
		wreg(UBS_OFF_ORDER, 8'h00);
		word = 1'b1;
		rchk(UBS_OFF_FIFO, 16'h00FF, {8'h00, q[1]});
		rchk(UBS_OFF_FIFO, 16'hFFFF, {q[2], q[1]});
		word = 1'b0;
		$display("iso test done");
		i_ubs_host_model.send('{rnd(), rnd()}, 1'b0);
		wreg(UBS_OFF_INDEX, 8'h03);
		wreg(UBS_OFF_CIE, 8'h04);
		cen = 1'b1;
		i_ubs_host_model.line(UBS_LINE_RESET, 6);
		tick(4);
		chk({14'h0000, cflg, irq}, 16'h0003);
		chk({9'h000, madr}, 16'h0000);
		rchk(UBS_OFF_FADDR, 16'h00FF, 16'h0000);
		rchk(UBS_OFF_INDEX, 16'h00FF, 16'h0000);
		rchk(UBS_OFF_CSO, 16'h00FF, 16'h0000);
		rchk(UBS_OFF_CIE, 16'h00FF, 16'h0006);
		rchk(UBS_OFF_CIF, 16'h000F, 16'h0004);
		rchk(UBS_OFF_CIF, 16'h000F, 16'h0000);
		chk({14'h0000, cflg, irq}, 16'h0000);
		p = '{rnd()};
		i_ubs_host_model.send(p, 1'b0);
		rchk(UBS_OFF_FIFO, 16'h00FF, {8'h00, p[0]});
		$display("bus reset test done");
		wreg(UBS_OFF_POWER, 8'h01);
		wreg(UBS_OFF_CIE, 8'h07);
		tick(60);
		chk({14'h0000, cflg, irq}, 16'h0003);
		rchk(UBS_OFF_POWER, 16'h0002, 16'h0002);
		n_wake = 0;
		i_ubs_host_model.line(UBS_LINE_ACTIVE, 3);
		tick(4);
		chk(16'(n_wake), 16'h0001);
		tick(20);
		rchk(UBS_OFF_CIF, 16'h000F, 16'h0003);
		rchk(UBS_OFF_POWER, 16'h0002, 16'h0000);
		tick(60);
		rchk(UBS_OFF_POWER, 16'h0002, 16'h0002);
		wreg(UBS_OFF_POWER, 8'h05);
		chk({15'h0000, drs}, 16'h0001);
		rchk(UBS_OFF_POWER, 16'h0002, 16'h0000);
		tick(10);
		wreg(UBS_OFF_POWER, 8'h01);
		chk({15'h0000, drs}, 16'h0000);
		tick(60);
		i_ubs_host_model.line(UBS_LINE_RESET, 6);
		tick(4);
		rchk(UBS_OFF_CIF, 16'h0006, 16'h0004);
		$display("sleep test done");
		wreg(UBS_OFF_FADDR, 8'h2A);
		dpm = 1'b1;
		tick(2);
		dpm = 1'b0;
		tick(1);
		rchk(UBS_OFF_FADDR, 16'h00FF, 16'h0000);
		chk({15'h0000, dma}, 16'h0000);
		$display("power test done");
		stop_test();
	end
endmodule
`default_nettype wire
